// File: input_scaling_output_routing.sv
// Input scaling, output routing, control action and key mode entry
// Contract
// - Input type 0..21, reset value 2
// - Temperature type hides scaling and decimal point
// - Celsius or Fahrenheit unit, Celsius default
// - Temperature shift interpolated between two offsets
// - Two shift offsets, both reset zero
// - Analog input maps range to scaling limits
// - Decimal point gives fractional digit count
// - Ten functions routed, only permitted destinations
// - Control outputs take control, alarms, signals
// - Cool assigned selects heating and cooling
// - Reset routing heat, alarm1, alarm2
// - Direct action inverts heating manipulated variable sense
// - Action selection defaults to reverse
// - Heat period 20 s; cool period refused unassigned
// - Mode entered after one second key hold
// - Setup shows input type, then unit
// - Level 2 shows local/remote first, shifts later
// - Level 1 shows proportional band first
`timescale 1ns/10ps
module input_scaling_output_routing #(
    parameter int unsigned HOLD_CYCLES = isor_pkg::KEY_HOLD_CYC,
    parameter int unsigned CENTI_CYCLES = isor_pkg::CENTI_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] rawIn,
    input  wire logic [6:0]  mvHeat,
    input  wire logic [6:0]  mvCool,
    input  wire logic [7:0]  funcIn,
    input  wire logic        keyMode,
    input  wire logic        keyAdvance,
    input  wire logic [1:0]  modeSelect,
    output logic             controlOutputOne,
    output logic             controlOutputTwo,
    output logic             auxiliaryOutputOne,
    output logic             heatCoolMode,
    output logic [1:0]       menuMode,
    output logic [3:0]       paramIndex,
    output logic             irq
);
    isor_pkg::isor_state_t   st_ff;
    isor_pkg::isor_state_t   nxt_st;
    isor_pkg::isor_apb_req_t req;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};

    // Legal destination for a function code
    function automatic logic legalCtrl(input logic [3:0] f);
        legalCtrl = (f <= isor_pkg::FN_STAGE);
    endfunction

    function automatic logic legalAux(input logic [3:0] f);
        legalAux = (f >= isor_pkg::FN_ALM1) &&
                   (f <= isor_pkg::FN_STAGE);
    endfunction

    always_comb begin
        logic               isTemp;
        logic               coolOn;
        logic               wrEn;
        logic               setupEn;
        logic               refuse;
        logic               adv;
        logic               centiTick;
        logic [2:0]         setBits;
        logic [31:0]        rd;
        logic signed [23:0] lo;
        logic signed [23:0] hi;
        logic signed [23:0] base;
        logic signed [23:0] pvs;
        logic signed [47:0] pr;
        logic signed [47:0] prS;
        logic signed [31:0] pvF;
        logic [6:0]         effHeat;
        logic [15:0]        heatSpan;
        logic [15:0]        coolSpan;
        logic               heatPwm;
        logic               coolPwm;
        logic [3:0]         asg2;
        logic [3:0]         asgA;
        isTemp = 1'b0;
        coolOn = 1'b0;
        wrEn = 1'b0;
        setupEn = 1'b0;
        refuse = 1'b0;
        adv = 1'b0;
        centiTick = 1'b0;
        setBits = 3'h0;
        rd = 32'h0;
        lo = 24'sh0;
        hi = 24'sh0;
        base = 24'sh0;
        pvs = 24'sh0;
        pr = 48'sh0;
        prS = 48'sh0;
        pvF = 32'sh0;
        effHeat = 7'h0;
        heatSpan = 16'h0;
        coolSpan = 16'h0;
        heatPwm = 1'b0;
        coolPwm = 1'b0;
        asg2 = 4'h0;
        asgA = 4'h0;
        nxt_st = st_ff;

        isTemp = (st_ff.inType < isor_pkg::ANALOG_MIN);
        coolOn = (st_ff.asg1 == isor_pkg::FN_COOL) ||
                 (st_ff.asg2 == isor_pkg::FN_COOL);
        nxt_st.hcMode = coolOn;

        // Measurement path
        if (isTemp) begin
            lo = 24'sh0;
            hi = isor_pkg::sensorHi(st_ff.inType);
            pr = $signed({25'h0, rawIn}) * (hi - lo);
            base = lo + pr[39:16];
            prS = $signed({25'h0, rawIn}) *
                  ($signed({{8{st_ff.shiftHi[15]}}, st_ff.shiftHi}) -
                   $signed({{8{st_ff.shiftLo[15]}}, st_ff.shiftLo}));
            pvs = base + $signed({{8{st_ff.shiftLo[15]}}, st_ff.shiftLo})
                  + prS[39:16];
            if (st_ff.unitF) begin
                pvF = (32'(pvs) * 32'sd9) / 32'sd5 + 32'sd320;
            end else begin
                pvF = 32'(pvs);
            end
        end else begin
            lo = $signed({{8{st_ff.scaleLo[15]}}, st_ff.scaleLo});
            hi = $signed({{8{st_ff.scaleHi[15]}}, st_ff.scaleHi});
            pr = $signed({25'h0, rawIn}) * (hi - lo);
            pvF = 32'(lo + pr[39:16]);
        end
        nxt_st.pv = pvF[15:0];

        // Register bus
        // Writes land at the access edge with pready high
        wrEn = req.psel && req.penable && st_ff.pready && req.pwrite;
        setupEn = req.psel && !req.penable;
        nxt_st.pready = setupEn;
        nxt_st.pslverr = 1'b0;
        if (req.paddr == isor_pkg::OFS_INTYPE) begin
            rd = {27'h0, st_ff.inType};
            if (wrEn) begin
                if (req.pwdata[4:0] <= isor_pkg::INTYPE_MAX) begin
                    nxt_st.inType = req.pwdata[4:0];
                end else begin
                    refuse = 1'b1;
                end
            end
        end else if (req.paddr == isor_pkg::OFS_UNIT) begin
            rd = {31'h0, st_ff.unitF};
            if (wrEn) begin
                nxt_st.unitF = req.pwdata[0];
            end
        end else if (req.paddr == isor_pkg::OFS_SHIFTHI) begin
            rd = {16'h0, st_ff.shiftHi};
            if (wrEn) begin
                nxt_st.shiftHi = req.pwdata[15:0];
            end
        end else if (req.paddr == isor_pkg::OFS_SHIFTLO) begin
            rd = {16'h0, st_ff.shiftLo};
            if (wrEn) begin
                nxt_st.shiftLo = req.pwdata[15:0];
            end
        end else if (req.paddr == isor_pkg::OFS_SCALEHI) begin
            rd = isTemp ? 32'h0 : {16'h0, st_ff.scaleHi};
            if (wrEn) begin
                if (isTemp) begin
                    refuse = 1'b1;
                end else begin
                    nxt_st.scaleHi = req.pwdata[15:0];
                end
            end
        end else if (req.paddr == isor_pkg::OFS_SCALELO) begin
            rd = isTemp ? 32'h0 : {16'h0, st_ff.scaleLo};
            if (wrEn) begin
                if (isTemp) begin
                    refuse = 1'b1;
                end else begin
                    nxt_st.scaleLo = req.pwdata[15:0];
                end
            end
        end else if (req.paddr == isor_pkg::OFS_DECPT) begin
            rd = isTemp ? 32'h0 : {30'h0, st_ff.decPt};
            if (wrEn) begin
                if (isTemp) begin
                    refuse = 1'b1;
                end else begin
                    nxt_st.decPt = req.pwdata[1:0];
                end
            end
        end else if (req.paddr == isor_pkg::OFS_ASSIGN) begin
            rd = {20'h0, st_ff.asgAux, st_ff.asg2, st_ff.asg1};
            asg2 = req.pwdata[isor_pkg::ASG_OUT2_POS +: 4];
            asgA = req.pwdata[isor_pkg::ASG_AUX_POS +: 4];
            if (wrEn) begin
                if (legalCtrl(req.pwdata[3:0]) && legalCtrl(asg2) &&
                    legalAux(asgA)) begin
                    nxt_st.asg1 = req.pwdata[3:0];
                    nxt_st.asg2 = asg2;
                    nxt_st.asgAux = asgA;
                end else begin
                    refuse = 1'b1;
                end
            end
        end else if (req.paddr == isor_pkg::OFS_ACTION) begin
            rd = {31'h0, st_ff.reverse};
            if (wrEn) begin
                nxt_st.reverse = req.pwdata[0];
            end
        end else if (req.paddr == isor_pkg::OFS_HEATPER) begin
            rd = {24'h0, st_ff.heatPer};
            if (wrEn && req.pwdata[7:0] != 8'h0) begin
                nxt_st.heatPer = req.pwdata[7:0];
            end else if (wrEn) begin
                refuse = 1'b1;
            end
        end else if (req.paddr == isor_pkg::OFS_COOLPER) begin
            rd = {24'h0, st_ff.coolPer};
            if (wrEn) begin
                if (coolOn && req.pwdata[7:0] != 8'h0) begin
                    nxt_st.coolPer = req.pwdata[7:0];
                end else begin
                    refuse = 1'b1;
                end
            end
        end else if (req.paddr == isor_pkg::OFS_STATE) begin
            rd = {24'h0, st_ff.pIdx, st_ff.menu, isTemp, st_ff.hcMode};
        end else if (req.paddr == isor_pkg::OFS_PV) begin
            rd = {{16{st_ff.pv[15]}}, st_ff.pv};
        end else if (req.paddr == isor_pkg::OFS_IRQSTAT) begin
            rd = {29'h0, st_ff.irqStat};
        end else if (req.paddr == isor_pkg::OFS_IRQCLR) begin
            rd = 32'h0;
        end else if (req.paddr == isor_pkg::OFS_IRQEN) begin
            rd = {29'h0, st_ff.irqEn};
            if (wrEn) begin
                nxt_st.irqEn = req.pwdata[2:0];
            end
        end else begin
            nxt_st.pslverr = setupEn;
        end
        if (setupEn) begin
            nxt_st.prdata = req.pwrite ? 32'h0 : rd;
        end

        // Key hold and parameter walk
        adv = keyAdvance && !st_ff.advPrev;
        nxt_st.advPrev = keyAdvance;
        if (!keyMode) begin
            nxt_st.holdCnt = 32'h0;
            nxt_st.holdDone = 1'b0;
        end else if (!st_ff.holdDone) begin
            if (st_ff.holdCnt == HOLD_CYCLES - 1) begin
                nxt_st.holdDone = 1'b1;
                nxt_st.menu = isor_pkg::isor_menu_t'(modeSelect);
                nxt_st.pIdx = 4'h0;
                setBits[isor_pkg::IRQ_MODE] = 1'b1;
            end else begin
                nxt_st.holdCnt = st_ff.holdCnt + 32'h1;
            end
        end
        if (adv && st_ff.menu != isor_pkg::MENU_OPER && !nxt_st.holdDone) begin
            nxt_st.pIdx = st_ff.pIdx + 4'h1;
            setBits[isor_pkg::IRQ_ADV] = 1'b1;
        end
        setBits[isor_pkg::IRQ_REFUSE] = refuse;

        // Interrupt status, set wins over clear
        if (wrEn && req.paddr == isor_pkg::OFS_IRQCLR) begin
            nxt_st.irqStat = (st_ff.irqStat & ~req.pwdata[2:0]) | setBits;
        end else begin
            nxt_st.irqStat = st_ff.irqStat | setBits;
        end
        nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqEn);

        // Time proportioning
        centiTick = (st_ff.centiCnt == CENTI_CYCLES - 1);
        nxt_st.centiCnt = centiTick ? 32'h0 : st_ff.centiCnt + 32'h1;
        heatSpan = 16'(st_ff.heatPer * 100);
        coolSpan = 16'(st_ff.coolPer * 100);
        if (centiTick) begin
            nxt_st.phaseH = (st_ff.phaseH >= heatSpan - 16'h1) ?
                            16'h0 : st_ff.phaseH + 16'h1;
            nxt_st.phaseC = (st_ff.phaseC >= coolSpan - 16'h1) ?
                            16'h0 : st_ff.phaseC + 16'h1;
        end
        effHeat = st_ff.reverse ? mvHeat :
                  7'(isor_pkg::MV_FULL - mvHeat);
        heatPwm = st_ff.phaseH < 16'(effHeat * st_ff.heatPer);
        coolPwm = coolOn &&
                  (st_ff.phaseC < 16'(mvCool * st_ff.coolPer));

        nxt_st.ctrlOne = route(st_ff.asg1, heatPwm, coolPwm);
        nxt_st.out2 = route(st_ff.asg2, heatPwm, coolPwm);
        nxt_st.aux = route(st_ff.asgAux, heatPwm, coolPwm);
    end

    // Level of an output function
    function automatic logic route(input logic [3:0] f, input logic h,
                                   input logic c);
        if (f == isor_pkg::FN_HEAT) begin
            route = h;
        end else if (f == isor_pkg::FN_COOL) begin
            route = c;
        end else if (f <= isor_pkg::FN_STAGE) begin
            route = funcIn[3'(f - isor_pkg::FN_ALM1)];
        end else begin
            route = 1'b0;
        end
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.inType <= isor_pkg::RST_INTYPE;
            st_ff.unitF <= isor_pkg::RST_UNITF;
            st_ff.shiftHi <= isor_pkg::RST_SHIFT;
            st_ff.shiftLo <= isor_pkg::RST_SHIFT;
            st_ff.scaleHi <= isor_pkg::RST_SCALEHI;
            st_ff.scaleLo <= isor_pkg::RST_SCALELO;
            st_ff.decPt <= isor_pkg::RST_DECPT;
            st_ff.asg1 <= isor_pkg::FN_HEAT;
            st_ff.asg2 <= isor_pkg::FN_ALM1;
            st_ff.asgAux <= isor_pkg::FN_ALM2;
            st_ff.reverse <= isor_pkg::RST_REVERSE;
            st_ff.heatPer <= isor_pkg::RST_HEATPER;
            st_ff.coolPer <= isor_pkg::RST_COOLPER;
            st_ff.menu <= isor_pkg::MENU_OPER;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign controlOutputOne = st_ff.ctrlOne;
    assign controlOutputTwo = st_ff.out2;
    assign auxiliaryOutputOne = st_ff.aux;
    assign heatCoolMode = st_ff.hcMode;
    assign menuMode = st_ff.menu;
    assign paramIndex = st_ff.pIdx;
    assign irq = st_ff.irq;
endmodule // input_scaling_output_routing

// File: isor_assertions.sv
// Port checker for the input scaling and output routing block
`timescale 1ns/10ps
module isor_assertions #(
    parameter int unsigned HOLD_CYCLES = 20
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        keyMode,
    input wire logic        keyAdvance,
    input wire logic        heatCoolMode,
    input wire logic [1:0]  menuMode,
    input wire logic [3:0]  paramIndex
);
    logic [31:0] holdRun_ff;
    logic [31:0] nxt_holdRun;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Consecutive cycles of mode key held
    always_comb begin
        nxt_holdRun = keyMode ? holdRun_ff + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk) begin
        holdRun_ff <= rst ? 32'h0 : nxt_holdRun;
    end

    AST_PREADY_NEXT:
    assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_PREADY_ONE:
    assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED:
    assert property (psel && !penable && paddr > 8'h3c |=>
                     pslverr && prdata == 32'h0)
        else $error("unmapped access not flagged");
    AST_ERR_CAUSE:
    assert property (pslverr |-> $past(paddr) > 8'h3c)
        else $error("error on mapped address");
    AST_KEY_HOLD:
    assert property (!$stable(menuMode) |-> holdRun_ff >= HOLD_CYCLES - 1)
        else $error("menu entered without long key hold");
    AST_ENTRY_IDX:
    assert property (!$stable(menuMode) |-> paramIndex == 4'h0)
        else $error("menu entry not at first parameter");
    AST_ADVANCE:
    assert property ($rose(keyAdvance) && menuMode != 2'h0 && !keyMode
                     |=> paramIndex == 4'($past(paramIndex) + 4'h1))
        else $error("advance did not step index");
    AST_OPER_IDX:
    assert property (menuMode == 2'h0 |-> paramIndex == 4'h0)
        else $error("index moved outside a menu");
    AST_HC_BY_WRITE:
    assert property (!$stable(heatCoolMode) |->
                     $past(psel, 2) && $past(pwrite, 2))
        else $error("control method changed without write");
endmodule // isor_assertions

bind input_scaling_output_routing isor_assertions #(
    .HOLD_CYCLES(HOLD_CYCLES)
) isor_assertions_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .keyMode, .keyAdvance, .heatCoolMode, .menuMode,
    .paramIndex);

// File: isor_key_model.sv
// Front-panel key model pressed on command of the bench
`timescale 1ns/10ps
module isor_key_model (
    input wire logic clk,
    output logic     keyMode,
    output logic     keyAdvance,
    output logic [1:0] modeSelect
);
    initial begin
        keyMode = 1'b0;
        keyAdvance = 1'b0;
        modeSelect = 2'h0;
    end

    // Hold mode key for a count of cycles with a menu chosen
    task automatic pressMode(input logic [1:0] sel, input int cycles);
        @(posedge clk);
        modeSelect <= sel;
        keyMode <= 1'b1;
        repeat (cycles) @(posedge clk);
        keyMode <= 1'b0;
        @(posedge clk);
    endtask

    // One press of the advance key
    task automatic pressAdvance();
        @(posedge clk);
        keyAdvance <= 1'b1;
        repeat (3) @(posedge clk);
        keyAdvance <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule // isor_key_model

// File: isor_pkg.sv
// Package: constants, codes and state types of the input scaling block
package isor_pkg;
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned KEY_HOLD_MS  = 1000;
    localparam int unsigned CENTI_SEC_MS = 10;
    localparam int unsigned KEY_HOLD_CYC = KEY_HOLD_MS * CLK_MHZ * 1000;
    localparam int unsigned CENTI_CYC    = CENTI_SEC_MS * CLK_MHZ * 1000;

    // Register byte offsets
    localparam logic [7:0] OFS_INTYPE  = 8'h00;
    localparam logic [7:0] OFS_UNIT    = 8'h04;
    localparam logic [7:0] OFS_SHIFTHI = 8'h08;
    localparam logic [7:0] OFS_SHIFTLO = 8'h0c;
    localparam logic [7:0] OFS_SCALEHI = 8'h10;
    localparam logic [7:0] OFS_SCALELO = 8'h14;
    localparam logic [7:0] OFS_DECPT   = 8'h18;
    localparam logic [7:0] OFS_ASSIGN  = 8'h1c;
    localparam logic [7:0] OFS_ACTION  = 8'h20;
    localparam logic [7:0] OFS_HEATPER = 8'h24;
    localparam logic [7:0] OFS_COOLPER = 8'h28;
    localparam logic [7:0] OFS_STATE   = 8'h2c;
    localparam logic [7:0] OFS_PV      = 8'h30;
    localparam logic [7:0] OFS_IRQSTAT = 8'h34;
    localparam logic [7:0] OFS_IRQCLR  = 8'h38;
    localparam logic [7:0] OFS_IRQEN   = 8'h3c;

    // Field positions
    localparam int unsigned ASG_OUT2_POS = 4;
    localparam int unsigned ASG_AUX_POS  = 8;
    localparam int unsigned ST_MENU_POS  = 2;
    localparam int unsigned ST_IDX_POS   = 4;

    // Reset values and limits
    localparam logic [4:0]  RST_INTYPE  = 5'h02;
    localparam logic [4:0]  INTYPE_MAX  = 5'h15;
    localparam logic [4:0]  ANALOG_MIN  = 5'h11;
    localparam logic        RST_UNITF   = 1'h0;
    localparam logic [15:0] RST_SHIFT   = 16'h0000;
    localparam logic [15:0] RST_SCALEHI = 16'h03e8;
    localparam logic [15:0] RST_SCALELO = 16'h0000;
    localparam logic [1:0]  RST_DECPT   = 2'h0;
    localparam logic        RST_REVERSE = 1'h1;
    localparam logic [7:0]  RST_HEATPER = 8'h14;
    localparam logic [7:0]  RST_COOLPER = 8'h14;
    localparam logic [6:0]  MV_FULL     = 7'h64;

    // Output function codes
    localparam logic [3:0] FN_HEAT  = 4'h0;
    localparam logic [3:0] FN_COOL  = 4'h1;
    localparam logic [3:0] FN_ALM1  = 4'h2;
    localparam logic [3:0] FN_ALM2  = 4'h3;
    localparam logic [3:0] FN_STAGE = 4'h9;
    localparam logic [3:0] FN_ERR2  = 4'hb;

    // Interrupt bits
    localparam int unsigned IRQ_MODE   = 0;
    localparam int unsigned IRQ_REFUSE = 1;
    localparam int unsigned IRQ_ADV    = 2;

    typedef enum logic [1:0] {
        MENU_OPER, MENU_SETUP, MENU_LEVEL1, MENU_LEVEL2
    } isor_menu_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } isor_apb_req_t;

    typedef struct packed {
        logic [4:0]  inType;
        logic        unitF;
        logic [15:0] shiftHi;
        logic [15:0] shiftLo;
        logic [15:0] scaleHi;
        logic [15:0] scaleLo;
        logic [1:0]  decPt;
        logic [3:0]  asg1;
        logic [3:0]  asg2;
        logic [3:0]  asgAux;
        logic        reverse;
        logic [7:0]  heatPer;
        logic [7:0]  coolPer;
        logic [15:0] pv;
        logic [2:0]  irqStat;
        logic [2:0]  irqEn;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [31:0] holdCnt;
        logic        holdDone;
        isor_menu_t  menu;
        logic [3:0]  pIdx;
        logic        advPrev;
        logic [31:0] centiCnt;
        logic [15:0] phaseH;
        logic [15:0] phaseC;
        logic        ctrlOne;
        logic        out2;
        logic        aux;
        logic        hcMode;
        logic        irq;
    } isor_state_t;

    // Sensor span upper end in tenths, lower end is zero
    function automatic logic signed [23:0] sensorHi(input logic [4:0] t);
        sensorHi = 24'(200 + 100 * int'(t));
    endfunction
endpackage

// File: tb.sv
// Self-checking bench of the input scaling and output routing block
`timescale 1ns/10ps
`define CHK(g, x) begin checkCount++; if ((g) !== (x)) begin \
    miscompares++; $display("[FAIL] %0t got %0h exp %0h", $time, g, x); \
    end end
module tb;
    logic clk = 1'b0, rst, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr, funcIn;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] rawIn;
    logic [6:0] mvHeat, mvCool;
    logic keyMode, keyAdvance, ctrlOne, out2, aux, heatCoolMode;
    logic [1:0] modeSelect, menuMode;
    logic [3:0] paramIndex;
    int miscompares = 0, checkCount = 0, cycles = 0;
    logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c,
                            8'h20, 8'h24, 8'h2c, 8'h34};
    logic [11:0] rv [10] = '{12'h2, 12'h0, 12'h0, 12'h0, 12'h0, 12'h320,
                             12'h1, 12'h14, 12'h2, 12'h0};

    always #2 clk = ~clk;

    input_scaling_output_routing #(.HOLD_CYCLES(20), .CENTI_CYCLES(2))
    input_scaling_output_routing_i (.clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rawIn, .mvHeat,
        .mvCool, .funcIn, .keyMode, .keyAdvance, .modeSelect,
        .controlOutputOne(ctrlOne), .controlOutputTwo(out2),
        .auxiliaryOutputOne(aux), .heatCoolMode, .menuMode, .paramIndex,
        .irq);
    isor_key_model isor_key_model_i (.clk, .keyMode, .keyAdvance,
        .modeSelect);

    task automatic endSim();
        if (miscompares == 0 && checkCount > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask

    task automatic pwm(input int x);
        int n;
        n = 0;
        repeat (200) @(posedge clk);
        repeat (200) begin
            @(posedge clk);
            n += (ctrlOne === 1'b1);
        end
        `CHK(n, x)
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            endSim();
        end
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, funcIn} = '0;
        rawIn = 16'h0;
        mvHeat = 7'h19;
        mvCool = 7'h32;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) rd(ra[i], 32'(rv[i]));
        apb(1'b0, 8'h40, 32'h0);
        `CHK(e, 1'b1)
        wr(8'h00, 32'h15);
        rd(8'h00, 32'h15);
        wr(8'h00, 32'h16);
        rd(8'h00, 32'h15);
        wr(8'h00, 32'h2);
        wr(8'h10, 32'h50);
        rd(8'h10, 32'h0);
        wr(8'h00, 32'h11);
        rd(8'h10, 32'h3e8);
        wr(8'h18, 32'h1);
        rd(8'h18, 32'h1);
        wr(8'h14, 32'h64);
        wr(8'h10, 32'h44c);
        rd(8'h30, 32'h64);
        rawIn <= 16'h8000;
        repeat (2) @(posedge clk);
        rd(8'h30, 32'h258);
        wr(8'h00, 32'h2);
        wr(8'h08, 32'h1e);
        wr(8'h0c, 32'ha);
        rd(8'h30, 32'hdc);
        rawIn <= 16'h0;
        wr(8'h04, 32'h1);
        rd(8'h30, 32'h152);
        wr(8'h04, 32'h0);
        rd(8'h30, 32'ha);
        wr(8'h28, 32'h5);
        rd(8'h28, 32'h14);
        wr(8'h24, 32'h0);
        rd(8'h24, 32'h14);
        wr(8'h1c, 32'h310);
        rd(8'h2c, 32'h3);
        wr(8'h28, 32'h5);
        rd(8'h28, 32'h5);
        wr(8'h1c, 32'h0b0);
        wr(8'h1c, 32'h010);
        rd(8'h1c, 32'h310);
        for (int c = 0; c < 10; c++) begin
            wr(8'h1c, 32'h320 | 32'(c));
            rd(8'h1c, 32'h320 | 32'(c));
            if (c > 1) begin
                funcIn <= 8'(1 << (c - 2));
                repeat (3) @(posedge clk);
                `CHK(ctrlOne, 1'b1)
                funcIn <= 8'h0;
                repeat (3) @(posedge clk);
                `CHK(ctrlOne, 1'b0)
            end
        end
        wr(8'h1c, 32'h320);
        `CHK(heatCoolMode, 1'b0)
        funcIn <= 8'h3;
        repeat (3) @(posedge clk);
        `CHK(out2 & aux, 1'b1)
        wr(8'h24, 32'h1);
        pwm(50);
        wr(8'h20, 32'h0);
        pwm(150);
        wr(8'h1c, 32'h321);
        wr(8'h28, 32'h1);
        pwm(100);
        wr(8'h1c, 32'h320);
        repeat (2) @(posedge clk);
        `CHK(heatCoolMode, 1'b0)
        isor_key_model_i.pressMode(2'h1, 15);
        `CHK(menuMode, 2'h0)
        isor_key_model_i.pressMode(2'h1, 24);
        `CHK({menuMode, paramIndex}, 6'h10)
        isor_key_model_i.pressAdvance();
        rd(8'h2c, 32'h16);
        isor_key_model_i.pressMode(2'h2, 24);
        `CHK({menuMode, paramIndex}, 6'h20)
        isor_key_model_i.pressMode(2'h3, 24);
        `CHK({menuMode, paramIndex}, 6'h30)
        rd(8'h34, 32'h7);
        wr(8'h3c, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(8'h3c, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(8'h3c, 32'h1);
        wr(8'h38, 32'h7);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(8'h34, 32'h0);
        endSim();
    end
endmodule // tb
